// ==== pkg/fet_defines.svh ====
// Register map, selection codes, reset values and field positions of the function enable block
`ifndef FET_DEFINES_SVH
`define FET_DEFINES_SVH

// Register byte addresses
`define FET_ADDR_SEL_LO 12'h000
`define FET_ADDR_SEL_HI 12'h004
`define FET_ADDR_TRAVEL 12'h008
`define FET_ADDR_SEQ_TORQUE 12'h00c
`define FET_ADDR_LOW_SPEED 12'h010
`define FET_ADDR_ALARM_CLASS 12'h014
`define FET_ADDR_STATUS 12'h018
`define FET_ADDR_ALARMS 12'h01c

// Reset values
`define FET_RST_SEL 32'h0000_0000
`define FET_RST_TRAVEL 3'h0
`define FET_RST_SEQ_TORQUE 16'h0000
`define FET_RST_LOW_SPEED 16'h0000
`define FET_RST_ALARM_CLASS 8'h00

// Function slots
`define FET_NUM_FUNC 8
`define FET_FN_EXCITE 0
`define FET_FN_ALARM_CLR 1
`define FET_FN_CW_LIMIT 2
`define FET_FN_CCW_LIMIT 3

// Selection codes
`define FET_SEL_OFF 8'h00
`define FET_SEL_ON 8'h01
`define FET_SEL_GIN_FIRST 8'h02
`define FET_SEL_GIN_LAST 8'h11
`define FET_SEL_LOWSPD_T 8'h12
`define FET_SEL_LOWSPD_F 8'h13
`define FET_SEL_REACH_T 8'h14
`define FET_SEL_REACH_F 8'h15
`define FET_SEL_MATCH_T 8'h16
`define FET_SEL_MATCH_F 8'h17
`define FET_SEL_ZSPD_T 8'h18
`define FET_SEL_ZSPD_F 8'h19
`define FET_SEL_INPOS_T 8'h1a
`define FET_SEL_INPOS_F 8'h1b
`define FET_SEL_TLIM_T 8'h1c
`define FET_SEL_TLIM_F 8'h1d
`define FET_SEL_SLIM_T 8'h1e
`define FET_SEL_SLIM_F 8'h1f
`define FET_SEL_NEAR_T 8'h20
`define FET_SEL_NEAR_F 8'h21
`define FET_SEL_CW_T 8'h22
`define FET_SEL_CW_F 8'h23
`define FET_SEL_CCW_T 8'h24
`define FET_SEL_CCW_F 8'h25
`define FET_SEL_ZSET_T 8'h26
`define FET_SEL_ZSET_F 8'h27

// Status register field positions
`define FET_ST_FEN_LSB 0
`define FET_ST_STATE_LSB 8
`define FET_ST_EXCITE_BIT 12
`define FET_ST_CW_ZERO_BIT 13
`define FET_ST_CCW_ZERO_BIT 14
`define FET_ST_GIN_LSB 16

`endif

// ==== pkg/fet_pkg.sv ====
// Types shared by the function enable and travel limit block
package fet_pkg;

  // Travel limit action codes
  typedef enum logic [2:0] {
    inhibit_servobrake_keep_on = 3'h0,
    inhibit_dynbrake_keep_on = 3'h1,
    inhibit_coast_keep_on = 3'h2,
    inhibit_servobrake_then_off = 3'h3,
    inhibit_dynbrake_then_off = 3'h4,
    inhibit_coast_then_off = 3'h5,
    zero_speed_limit_only = 3'h6
  } fet_action_t;

  // Stop sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_STOPPING = 4'b0010,
    ST_HOLD_ON = 4'b0100,
    ST_HOLD_OFF = 4'b1000
  } fet_state_t;

  // Braking method applied to the drive stage
  typedef enum logic [1:0] {
    BRAKE_NONE = 2'h0,
    BRAKE_SERVO = 2'h1,
    BRAKE_DYNAMIC = 2'h2,
    BRAKE_COAST = 2'h3
  } fet_brake_t;

  // Status flags from the motor control loops, same clock
  typedef struct packed {
    logic near;
    logic in_position;
    logic cmd_zero;
    logic torque_limiting;
    logic speed_limiting;
    logic low_speed;
    logic speed_reached;
    logic speed_match;
    logic zero_speed;
  } fet_status_t;

  // Commands toward the drive stage
  typedef struct packed {
    logic excitation_signal;
    logic cmd_inhibit;
    logic cw_speed_limit_zero;
    logic ccw_speed_limit_zero;
    fet_brake_t brake;
    logic [15:0] brake_torque_limit;
  } fet_drive_t;

endpackage

// ==== hdl/fet_function_enable.sv ====
// Function enable selection, travel limit stop sequencer, alarm latch and APB register file
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "fet_defines.svh"

module fet_function_enable
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Generic inputs from the host, asynchronous pins
  input wire logic [7:0] generic_input,
  // Motor loop status
  input wire fet_pkg::fet_status_t status,
  input wire logic signed [15:0] speed_monitor,
  input wire logic [15:0] peak_motor_torque,
  // Alarm sources
  input wire logic [7:0] alarm_raise,
  output logic [7:0] alarm_latched,
  // Function enables and drive commands
  output logic [7:0] func_enable,
  output fet_pkg::fet_drive_t drive
);

  // Register file
  logic [31:0] sel_lo_r;
  logic [31:0] sel_hi_r;
  fet_pkg::fet_action_t travel_action_r;
  logic [15:0] sequence_torque_limit_r;
  logic [15:0] low_speed_threshold_r;
  logic [7:0] alarm_class_r;
  logic [31:0] prdata_r;

  // Input synchronisers and filtered inputs
  logic [7:0] gin_s1_r;
  logic [7:0] gin_s2_r;
  logic [7:0] gin_s3_r;
  logic [7:0] gin_r;

  // Selection results
  logic [7:0] func_en_r;
  logic [7:0] func_en_nxt;
  logic rot_cw;
  logic rot_ccw;
  logic signed [16:0] thr_pos;
  logic signed [16:0] thr_neg;
  logic signed [16:0] speed_ext;

  // Sequencer and drive
  fet_pkg::fet_state_t state_r;
  fet_pkg::fet_state_t state_nxt;
  logic alarm_clr_prev_r;
  logic [7:0] alarm_r;
  logic excite_r;
  logic inhibit_r;
  logic cw_zero_r;
  logic ccw_zero_r;
  fet_pkg::fet_brake_t brake_r;
  logic [15:0] brake_torque_r;

  logic wr_en;
  logic rd_setup;
  logic addr_ok;
  logic [31:0] wmask;
  logic cw_event;
  logic ccw_event;
  logic any_event;
  logic keep_on;

  // Evaluate one selection code against inputs and flags
  function automatic logic sel_hit(
    input logic [7:0] code,
    input logic [7:0] gi,
    input fet_pkg::fet_status_t s,
    input logic cw,
    input logic ccw
  );
    logic hit;
    logic [7:0] ofs;
    hit = 1'b0;
    ofs = code - `FET_SEL_GIN_FIRST;
    if (code >= `FET_SEL_GIN_FIRST && code <= `FET_SEL_GIN_LAST)
    begin
      // Odd codes invert: same pin, either polarity
      hit = gi[ofs[3:1]] ^ code[0];
    end
    else
    begin
      case (code)
        `FET_SEL_OFF: hit = 1'b0;
        `FET_SEL_ON: hit = 1'b1;
        `FET_SEL_LOWSPD_T: hit = s.low_speed;
        `FET_SEL_LOWSPD_F: hit = ~s.low_speed;
        `FET_SEL_REACH_T: hit = s.speed_reached;
        `FET_SEL_REACH_F: hit = ~s.speed_reached;
        `FET_SEL_MATCH_T: hit = s.speed_match;
        `FET_SEL_MATCH_F: hit = ~s.speed_match;
        `FET_SEL_ZSPD_T: hit = s.zero_speed;
        `FET_SEL_ZSPD_F: hit = ~s.zero_speed;
        `FET_SEL_INPOS_T: hit = s.in_position;
        `FET_SEL_INPOS_F: hit = ~s.in_position;
        `FET_SEL_TLIM_T: hit = s.torque_limiting;
        `FET_SEL_TLIM_F: hit = ~s.torque_limiting;
        `FET_SEL_SLIM_T: hit = s.speed_limiting;
        `FET_SEL_SLIM_F: hit = ~s.speed_limiting;
        `FET_SEL_NEAR_T: hit = s.near;
        `FET_SEL_NEAR_F: hit = ~s.near;
        `FET_SEL_CW_T: hit = cw;
        `FET_SEL_CW_F: hit = ~cw;
        `FET_SEL_CCW_T: hit = ccw;
        `FET_SEL_CCW_F: hit = ~ccw;
        `FET_SEL_ZSET_T: hit = s.cmd_zero & s.in_position;
        `FET_SEL_ZSET_F: hit = ~(s.cmd_zero & s.in_position);
        // Codes outside the table leave the function inactive
        default: hit = 1'b0;
      endcase
    end
    return hit;
  endfunction

  // Three-stage synchroniser; a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_sync
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          gin_s1_r[gi] <= 1'b0;
          gin_s2_r[gi] <= 1'b0;
          gin_s3_r[gi] <= 1'b0;
          gin_r[gi] <= 1'b0;
        end
        else
        begin
          gin_s1_r[gi] <= generic_input[gi];
          gin_s2_r[gi] <= gin_s1_r[gi];
          gin_s3_r[gi] <= gin_s2_r[gi];
          if (gin_s2_r[gi] == gin_s3_r[gi])
          begin
            gin_r[gi] <= gin_s3_r[gi];
          end
        end
      end
    end
  endgenerate

  // Rotation direction against the low speed threshold, widened to avoid overflow on negation
  assign speed_ext = {speed_monitor[15], speed_monitor};
  assign thr_pos = {1'b0, low_speed_threshold_r};
  assign thr_neg = -thr_pos;
  assign rot_cw = speed_ext > thr_pos;
  assign rot_ccw = speed_ext < thr_neg;

  // Per-function selection
  generate
    for (gi = 0; gi < `FET_NUM_FUNC; gi++)
    begin : g_func
      logic [7:0] code;
      assign code = (gi < 4) ? sel_lo_r[(gi % 4) * 8 +: 8] : sel_hi_r[(gi % 4) * 8 +: 8];
      assign func_en_nxt[gi] = sel_hit(code, gin_r, status, rot_cw, rot_ccw);
    end
  endgenerate

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      func_en_r <= 8'h00;
    end
    else
    begin
      func_en_r <= func_en_nxt;
    end
  end

  assign func_enable = func_en_r;

  // Travel limit events
  assign cw_event = func_en_r[`FET_FN_CW_LIMIT];
  assign ccw_event = func_en_r[`FET_FN_CCW_LIMIT];
  assign any_event = cw_event | ccw_event;
  assign keep_on = travel_action_r inside {fet_pkg::inhibit_servobrake_keep_on,
    fet_pkg::inhibit_dynbrake_keep_on, fet_pkg::inhibit_coast_keep_on};

  // Stop sequencer; stop completion is taken from the zero speed flag
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      fet_pkg::ST_RUN:
      begin
        if (any_event && travel_action_r != fet_pkg::zero_speed_limit_only)
        begin
          state_nxt = fet_pkg::ST_STOPPING;
        end
      end
      fet_pkg::ST_STOPPING:
      begin
        if (!any_event)
        begin
          state_nxt = fet_pkg::ST_RUN;
        end
        else if (status.zero_speed)
        begin
          state_nxt = keep_on ? fet_pkg::ST_HOLD_ON : fet_pkg::ST_HOLD_OFF;
        end
      end
      fet_pkg::ST_HOLD_ON,
      fet_pkg::ST_HOLD_OFF:
      begin
        if (!any_event)
        begin
          state_nxt = fet_pkg::ST_RUN;
        end
      end
      default: state_nxt = fet_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= fet_pkg::ST_RUN;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Alarm latch: rising edge of the clear enable wipes clearable bits, new raises win
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      alarm_clr_prev_r <= 1'b0;
      alarm_r <= 8'h00;
    end
    else
    begin
      alarm_clr_prev_r <= func_en_r[`FET_FN_ALARM_CLR];
      if (func_en_r[`FET_FN_ALARM_CLR] && !alarm_clr_prev_r)
      begin
        alarm_r <= (alarm_r & alarm_class_r) | alarm_raise;
      end
      else
      begin
        alarm_r <= alarm_r | alarm_raise;
      end
    end
  end

  assign alarm_latched = alarm_r;

  // Drive commands
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      excite_r <= 1'b0;
      inhibit_r <= 1'b0;
      cw_zero_r <= 1'b0;
      ccw_zero_r <= 1'b0;
      brake_r <= fet_pkg::BRAKE_NONE;
    end
    else
    begin
      cw_zero_r <= cw_event;
      ccw_zero_r <= ccw_event;
      inhibit_r <= state_nxt != fet_pkg::ST_RUN;
      brake_r <= fet_pkg::BRAKE_NONE;
      if (state_nxt == fet_pkg::ST_STOPPING)
      begin
        unique case (travel_action_r)
          fet_pkg::inhibit_servobrake_keep_on,
          fet_pkg::inhibit_servobrake_then_off: brake_r <= fet_pkg::BRAKE_SERVO;
          fet_pkg::inhibit_dynbrake_keep_on,
          fet_pkg::inhibit_dynbrake_then_off: brake_r <= fet_pkg::BRAKE_DYNAMIC;
          default: brake_r <= fet_pkg::BRAKE_COAST;
        endcase
      end
      // Dynamic braking and coasting cannot run with current applied
      excite_r <= func_en_r[`FET_FN_EXCITE] && alarm_r == 8'h00
        && state_nxt != fet_pkg::ST_HOLD_OFF
        && !(state_nxt == fet_pkg::ST_STOPPING
             && travel_action_r != fet_pkg::inhibit_servobrake_keep_on
             && travel_action_r != fet_pkg::inhibit_servobrake_then_off);
    end
  end

  // Servo-brake torque bound, clamped to motor peak
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      brake_torque_r <= 16'h0000;
    end
    else if (sequence_torque_limit_r > peak_motor_torque)
    begin
      brake_torque_r <= peak_motor_torque;
    end
    else
    begin
      brake_torque_r <= sequence_torque_limit_r;
    end
  end

  assign drive.excitation_signal = excite_r;
  assign drive.cmd_inhibit = inhibit_r;
  assign drive.cw_speed_limit_zero = cw_zero_r;
  assign drive.ccw_speed_limit_zero = ccw_zero_r;
  assign drive.brake = brake_r;
  assign drive.brake_torque_limit = brake_torque_r;

  // APB: zero wait states, read data captured in the setup cycle
  assign wr_en = psel & penable & pwrite & addr_ok;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign addr_ok = paddr inside {`FET_ADDR_SEL_LO, `FET_ADDR_SEL_HI, `FET_ADDR_TRAVEL,
    `FET_ADDR_SEQ_TORQUE, `FET_ADDR_LOW_SPEED, `FET_ADDR_ALARM_CLASS, `FET_ADDR_STATUS,
    `FET_ADDR_ALARMS};
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata = prdata_r;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sel_lo_r <= `FET_RST_SEL;
      sel_hi_r <= `FET_RST_SEL;
      travel_action_r <= fet_pkg::fet_action_t'(`FET_RST_TRAVEL);
      sequence_torque_limit_r <= `FET_RST_SEQ_TORQUE;
      low_speed_threshold_r <= `FET_RST_LOW_SPEED;
      alarm_class_r <= `FET_RST_ALARM_CLASS;
    end
    else if (wr_en)
    begin
      case (paddr)
        `FET_ADDR_SEL_LO: sel_lo_r <= (sel_lo_r & ~wmask) | (pwdata & wmask);
        `FET_ADDR_SEL_HI: sel_hi_r <= (sel_hi_r & ~wmask) | (pwdata & wmask);
        `FET_ADDR_TRAVEL:
        begin
          // Code 7 in bits 2:0 is not an action; keep the previous one
          if (pstrb[0] && pwdata[2:0] != 3'h7)
          begin
            travel_action_r <= fet_pkg::fet_action_t'(pwdata[2:0]);
          end
        end
        `FET_ADDR_SEQ_TORQUE:
        begin
          if (pstrb[0])
          begin
            sequence_torque_limit_r[7:0] <= pwdata[7:0];
          end
          if (pstrb[1])
          begin
            sequence_torque_limit_r[15:8] <= pwdata[15:8];
          end
        end
        `FET_ADDR_LOW_SPEED:
        begin
          if (pstrb[0])
          begin
            low_speed_threshold_r[7:0] <= pwdata[7:0];
          end
          if (pstrb[1])
          begin
            low_speed_threshold_r[15:8] <= pwdata[15:8];
          end
        end
        `FET_ADDR_ALARM_CLASS:
        begin
          if (pstrb[0])
          begin
            alarm_class_r <= pwdata[7:0];
          end
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prdata_r <= 32'h0000_0000;
    end
    else if (rd_setup)
    begin
      case (paddr)
        `FET_ADDR_SEL_LO: prdata_r <= sel_lo_r;
        `FET_ADDR_SEL_HI: prdata_r <= sel_hi_r;
        `FET_ADDR_TRAVEL: prdata_r <= {29'h0000_0000, travel_action_r};
        `FET_ADDR_SEQ_TORQUE: prdata_r <= {16'h0000, sequence_torque_limit_r};
        `FET_ADDR_LOW_SPEED: prdata_r <= {16'h0000, low_speed_threshold_r};
        `FET_ADDR_ALARM_CLASS: prdata_r <= {24'h00_0000, alarm_class_r};
        `FET_ADDR_STATUS: prdata_r <= {8'h00, gin_r, 1'b0, ccw_zero_r, cw_zero_r, excite_r,
          state_r, func_en_r};
        `FET_ADDR_ALARMS: prdata_r <= {24'h00_0000, alarm_r};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ==== testbench/fet_fe_checker_asserts.sv ====
// Port-level assertions for the function enable block
`timescale 1ns/1ps
`include "fet_defines.svh"

module fet_fe_checker
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and loop status
  input wire logic [7:0] generic_input,
  input wire fet_pkg::fet_status_t status,
  input wire logic signed [15:0] speed_monitor,
  input wire logic [15:0] peak_motor_torque,
  // Alarms and outputs
  input wire logic [7:0] alarm_raise,
  input wire logic [7:0] alarm_latched,
  input wire logic [7:0] func_enable,
  input wire fet_pkg::fet_drive_t drive
);
  logic wr_ok;
  logic [2:0] act_r;
  logic [15:0] seq_r;
  logic [7:0] class_r;
  logic [15:0] tq_min;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  assign wr_ok = psel && penable && pwrite && pready && !pslverr;
  assign tq_min = (seq_r < peak_motor_torque) ? seq_r : peak_motor_torque;

  // Shadows of the registers that the checks depend on, committed on the same edge as the design
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      act_r <= 3'h0;
      seq_r <= 16'h0000;
      class_r <= 8'h00;
    end
    else if (wr_ok)
    begin
      if (paddr == `FET_ADDR_TRAVEL && pstrb[0] && pwdata[2:0] != 3'h7)
        act_r <= pwdata[2:0];
      if (paddr == `FET_ADDR_SEQ_TORQUE && pstrb[0])
        seq_r[7:0] <= pwdata[7:0];
      if (paddr == `FET_ADDR_SEQ_TORQUE && pstrb[1])
        seq_r[15:8] <= pwdata[15:8];
      if (paddr == `FET_ADDR_ALARM_CLASS && pstrb[0])
        class_r <= pwdata[7:0];
    end
  end

  a_cw_zero_follow: assert property (drive.cw_speed_limit_zero == $past(func_enable[2]))
    else $error("cw speed limit zero does not follow the cw limit");
  a_ccw_zero_follow: assert property (drive.ccw_speed_limit_zero == $past(func_enable[3]))
    else $error("ccw speed limit zero does not follow the ccw limit");
  a_limit_inhibits: assert property ((func_enable[2] || func_enable[3]) && act_r != 3'h6
    |=> drive.cmd_inhibit)
    else $error("travel limit did not inhibit commands");
  a_action6_run: assert property (act_r == 3'h6 && !drive.cmd_inhibit
    |=> !drive.cmd_inhibit && drive.brake == fet_pkg::BRAKE_NONE)
    else $error("speed-limit-only action changed the stop state");
  a_brake_when_stop: assert property (drive.brake != fet_pkg::BRAKE_NONE |-> drive.cmd_inhibit)
    else $error("brake applied outside a stop");
  a_dyn_coast_off: assert property (drive.brake inside {fet_pkg::BRAKE_DYNAMIC, fet_pkg::BRAKE_COAST}
    |-> !drive.excitation_signal)
    else $error("excitation on during dynamic brake or coast");
  a_torque_clamp: assert property (drive.brake_torque_limit == $past(tq_min))
    else $error("brake torque limit not min of setting and peak");
  a_alarm_clear: assert property ($rose(func_enable[1])
    |-> ##[1:2] (alarm_latched & ~class_r & ~$past(alarm_raise)) == 8'h00)
    else $error("clearable alarm survived a clear request");
  a_alarm_keep: assert property ((alarm_latched & class_r) != 8'h00
    |=> (alarm_latched & $past(alarm_latched & class_r)) == $past(alarm_latched & class_r))
    else $error("power-cycle alarm was cleared");
  a_excite_enable: assert property (drive.excitation_signal |-> $past(func_enable[0]))
    else $error("excitation without its function enabled");
endmodule

// ==== testbench/fet_host_model.sv ====
// Host controller model driving the generic input pins
`timescale 1ns/1ps

module fet_host_model
(
  // Clock
  input wire logic clk,
  // Requested pin levels and answer speed
  input wire logic [7:0] pins_cmd,
  input wire logic slow,
  // Pins
  output logic [7:0] generic_input
);
  logic [7:0] d1_r;
  logic [7:0] d2_r;

  // A slow host shows its new level two cycles late, as a relay-driven output would
  always_ff @(posedge clk)
  begin
    d1_r <= pins_cmd;
    d2_r <= d1_r;
  end

  assign generic_input = slow ? d2_r : pins_cmd;
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the function enable block
`timescale 1ns/1ps
`include "fet_defines.svh"

module testbench;
  typedef struct packed {logic [7:0] code; logic [8:0] st; logic [15:0] spd; logic [7:0] gin; logic en;} fet_row_t;

  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] pins_cmd = 8'h00;
  logic host_slow = 1'b0;
  logic [7:0] generic_input;
  fet_pkg::fet_status_t status = 9'h000;
  logic signed [15:0] speed_monitor = 16'sh0000;
  logic [15:0] peak_motor_torque = 16'h0200;
  logic [7:0] alarm_raise = 8'h00;
  logic [7:0] alarm_latched;
  logic [7:0] func_enable;
  fet_pkg::fet_drive_t drive;
  int fail_count = 0;
  int check_count = 0;
  // Code, status, speed, pins, expected enable; threshold is 100
  fet_row_t rows [35] = '{
    '{8'h00, 9'h1ff, 16'h0000, 8'hff, 1'b0}, '{8'h01, 9'h000, 16'h0000, 8'h00, 1'b1},
    '{8'h02, 9'h000, 16'h0000, 8'h01, 1'b1}, '{8'h03, 9'h000, 16'h0000, 8'h01, 1'b0},
    '{8'h03, 9'h000, 16'h0000, 8'hfe, 1'b1}, '{8'h10, 9'h000, 16'h0000, 8'h80, 1'b1},
    '{8'h11, 9'h000, 16'h0000, 8'h7f, 1'b1}, '{8'h04, 9'h000, 16'h0000, 8'hfd, 1'b0},
    '{8'h20, 9'h100, 16'h0000, 8'h00, 1'b1}, '{8'h21, 9'h0ff, 16'h0000, 8'h00, 1'b1},
    '{8'h21, 9'h100, 16'h0000, 8'h00, 1'b0}, '{8'h1a, 9'h080, 16'h0000, 8'h00, 1'b1},
    '{8'h1b, 9'h17f, 16'h0000, 8'h00, 1'b1}, '{8'h26, 9'h0c0, 16'h0000, 8'h00, 1'b1},
    '{8'h26, 9'h080, 16'h0000, 8'h00, 1'b0}, '{8'h27, 9'h040, 16'h0000, 8'h00, 1'b1},
    '{8'h27, 9'h0c0, 16'h0000, 8'h00, 1'b0}, '{8'h1c, 9'h020, 16'h0000, 8'h00, 1'b1},
    '{8'h1d, 9'h020, 16'h0000, 8'h00, 1'b0}, '{8'h1e, 9'h010, 16'h0000, 8'h00, 1'b1},
    '{8'h1f, 9'h1ef, 16'h0000, 8'h00, 1'b1}, '{8'h22, 9'h000, 16'h0065, 8'h00, 1'b1},
    '{8'h22, 9'h000, 16'h0064, 8'h00, 1'b0}, '{8'h23, 9'h000, 16'h0064, 8'h00, 1'b1},
    '{8'h23, 9'h000, 16'h0065, 8'h00, 1'b0}, '{8'h24, 9'h000, 16'hff9b, 8'h00, 1'b1},
    '{8'h24, 9'h000, 16'hff9c, 8'h00, 1'b0}, '{8'h25, 9'h000, 16'hff9c, 8'h00, 1'b1},
    '{8'h25, 9'h000, 16'hff9b, 8'h00, 1'b0}, '{8'h12, 9'h008, 16'h0000, 8'h00, 1'b1},
    '{8'h13, 9'h008, 16'h0000, 8'h00, 1'b0}, '{8'h14, 9'h004, 16'h0000, 8'h00, 1'b1},
    '{8'h17, 9'h002, 16'h0000, 8'h00, 1'b0}, '{8'h18, 9'h001, 16'h0000, 8'h00, 1'b1},
    '{8'h28, 9'h1ff, 16'h0000, 8'hff, 1'b0}};

  always #12.5 clk = ~clk;

  fet_host_model i_fet_host_model (.clk(clk), .pins_cmd(pins_cmd), .slow(host_slow), .generic_input(generic_input));

  fet_function_enable i_fet_function_enable (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .generic_input(generic_input), .status(status), .speed_monitor(speed_monitor),
    .peak_motor_torque(peak_motor_torque), .alarm_raise(alarm_raise), .alarm_latched(alarm_latched),
    .func_enable(func_enable), .drive(drive));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
    output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 20)
      fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, d, rd, e);
  endtask

  // Bounded wait; counts a failure if the enable never reaches the level
  task automatic wait_fe(input int idx, input logic v);
    int n;
    n = 0;
    while (func_enable[idx] !== v && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    if (func_enable[idx] !== v)
      fail_count++;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    logic [31:0] rd;
    logic err;
    int idx;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b0, `FET_ADDR_SEL_LO, 32'h0, rd, err);
    check(rd, `FET_RST_SEL);
    apb(1'b0, 12'h020, 32'h0, rd, err);
    check(err, 1'b1);
    check(rd, 32'h0);
    wr(`FET_ADDR_TRAVEL, 32'h3);
    wr(`FET_ADDR_TRAVEL, 32'h7);
    apb(1'b0, `FET_ADDR_TRAVEL, 32'h0, rd, err);
    check(rd, 32'h3);
    $display("test registers done");
    wr(`FET_ADDR_LOW_SPEED, 32'h64);
    for (int i = 0; i < 35; i++)
    begin
      @(posedge clk);
      status <= rows[i].st;
      speed_monitor <= rows[i].spd;
      pins_cmd <= rows[i].gin;
      wr(`FET_ADDR_SEL_HI, {24'h0, rows[i].code});
      repeat (8) @(posedge clk);
      check(func_enable[4], rows[i].en);
    end
    $display("test selection codes done");
    @(posedge clk);
    status <= 9'h000;
    speed_monitor <= 16'sh0000;
    pins_cmd <= 8'h00;
    wr(`FET_ADDR_SEL_LO, 32'h0602_0401);
    repeat (4) @(posedge clk);
    check(drive.excitation_signal, 1'b1);
    for (int a = 0; a < 7; a++)
    begin
      idx = (a % 2) ? 3 : 2;
      wr(`FET_ADDR_TRAVEL, a);
      @(posedge clk);
      host_slow <= a[0];
      pins_cmd <= (a % 2) ? 8'h04 : 8'h01;
      wait_fe(idx, 1'b1);
      repeat (2) @(posedge clk);
      check(drive.cw_speed_limit_zero, a % 2 == 0);
      check(drive.ccw_speed_limit_zero, a % 2 == 1);
      check(drive.cmd_inhibit, a != 6);
      check(drive.brake, (a == 6) ? 2'h0 : 2'(a % 3 + 1));
      check(drive.excitation_signal, a == 0 || a == 3 || a == 6);
      @(posedge clk);
      status <= 9'h001;
      repeat (3) @(posedge clk);
      check(drive.brake, 2'h0);
      check(drive.excitation_signal, a < 3 || a == 6);
      check(drive.cmd_inhibit, a != 6);
      @(posedge clk);
      status <= 9'h000;
      pins_cmd <= 8'h00;
      wait_fe(idx, 1'b0);
      repeat (3) @(posedge clk);
      check(drive.cmd_inhibit, 1'b0);
    end
    $display("test travel limit done");
    wr(`FET_ADDR_ALARM_CLASS, 32'h80);
    wr(`FET_ADDR_SEQ_TORQUE, 32'h0100);
    @(posedge clk);
    alarm_raise <= 8'h81;
    @(posedge clk);
    alarm_raise <= 8'h00;
    repeat (3) @(posedge clk);
    check(alarm_latched, 8'h81);
    check(drive.excitation_signal, 1'b0);
    check(drive.brake_torque_limit, 16'h0100);
    pins_cmd <= 8'h02;
    wait_fe(1, 1'b1);
    repeat (3) @(posedge clk);
    check(alarm_latched, 8'h80);
    pins_cmd <= 8'h00;
    wr(`FET_ADDR_SEQ_TORQUE, 32'h0300);
    repeat (3) @(posedge clk);
    check(drive.brake_torque_limit, 16'h0200);
    $display("test alarms and torque done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    check(alarm_latched, 8'h00);
    check(func_enable, 8'h00);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    $display("test second reset done");
    complete_run();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    complete_run();
  end
endmodule

bind fet_function_enable fet_fe_checker i_fet_fe_checker (.clk(clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .generic_input(generic_input), .status(status),
  .speed_monitor(speed_monitor), .peak_motor_torque(peak_motor_torque), .alarm_raise(alarm_raise),
  .alarm_latched(alarm_latched), .func_enable(func_enable), .drive(drive));
